// *** design/hazard_pkg.sv ***
// Constants and types for the system-register update hazard control block.
// Assumes a single core clock domain and an APB slave for software access.
// Behaviour
// RULE_01: Writes to groups 0,1,2,5,10,12,13 are seen by the very next instruction.
// RULE_02: Fetch sees new settings only after a synchronisation instruction.
// RULE_03: Mask and unmask instructions act exactly like a status word write.
// RULE_04: Pending interrupts after an acceptance-control write use the new settings.
// RULE_05: Bank registers act next instruction; bank restore after mode change needs sync.
// RULE_06: Region write right after an index write targets the newly indexed entry.
// RULE_07: Software syncs between index write and region read; reads use synced index.
// RULE_08: Fetch settings and other registers take effect after a sync instruction.
// RULE_09: Exception vectors use the vector base only while base select is 1.
// RULE_10: Software masks, clears select, writes base, sets select, then unmasks.
// RULE_11: In guest mode base select reads 1 and cannot be changed.
// RULE_12: Software changes user mode via the return instructions during that update.
// RULE_13: An unsynced write outside the set lands at an unspecified later point.
package hazard_pkg;
   // Instruction kinds seen on the issue port
   typedef enum logic [3:0] {
      OP_NOP        = 4'h0,
      OP_SR_WRITE   = 4'h1,
      OP_SR_READ    = 4'h2,
      OP_MASK       = 4'h3,
      OP_UNMASK     = 4'h4,
      OP_FETCH_SYNC = 4'h5,
      OP_PIPE_SYNC  = 4'h6,
      OP_BANK_REST  = 4'h7
   } op_e;

   // Register identities as group and number
   localparam logic [4:0] GRP_PSW     = 5'h00;
   localparam logic [4:0] NUM_PSW     = 5'h05;
   localparam logic [4:0] GRP_EXCEPTION_VECTOR_BASE   = 5'h01;
   localparam logic [4:0] NUM_EXCEPTION_VECTOR_BASE   = 5'h03;
   localparam logic [4:0] GRP_INT     = 5'h02;
   localparam logic [4:0] NUM_LEVEL   = 5'h0e;
   localparam logic [4:0] NUM_BANK0   = 5'h0f;
   localparam logic [4:0] GRP_MPU     = 5'h05;
   localparam logic [4:0] NUM_IDX     = 5'h10;
   localparam logic [4:0] NUM_LOWER   = 5'h14;
   localparam logic [4:0] NUM_UPPER   = 5'h15;
   localparam logic [4:0] NUM_ATTR    = 5'h16;
   localparam logic [4:0] GRP_OTHER   = 5'h03;
   localparam logic [4:0] NUM_OTHER   = 5'h00;

   // Status word fields
   localparam int PSW_ID  = 5;
   localparam int PSW_EBV = 15;
   localparam int PSW_UM  = 30;
   localparam logic [31:0] PSW_RESET   = 32'h0000_0020;
   localparam logic [31:0] EXCEPTION_VECTOR_BASE_RESET = 32'h0000_0000;
   localparam logic [3:0]  LEVEL_RESET = 4'hf;

   // APB map
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_PSW    = 8'h04;
   localparam logic [7:0] A_VECTOR = 8'h08;
   localparam logic [7:0] A_INDEX  = 8'h0c;
   localparam logic [7:0] A_HAZARD = 8'h10;

   // Late landing of unsynced writes outside the set, in cycles
   localparam logic [3:0] LATE_CYCLES = 4'h4;
endpackage

// *** design/sysreg_hazard.sv ***
// Hazard control for system-register updates in the core's execute stage.
// Assumes one instruction per cycle on the issue port, in program order.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module sysreg_hazard
#(
   parameter int          ENTRIES     = 8,
   parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              instr_valid,
   input  wire hazard_pkg::op_e   instr_op,
   input  wire logic [4:0]        register_group_select,
   input  wire logic [4:0]        instr_regnum,
   input  wire logic [31:0]       instr_wdata,
   output logic      [31:0]       instr_rdata,
   input  wire logic              irq_req,
   input  wire logic [3:0]        irq_level,
   output logic                   irq_accept,
   output logic      [31:0]       exec_psw,
   output logic      [31:0]       fetch_psw,
   output logic      [31:0]       fetch_exception_vector_base,
   output logic      [31:0]       vector_base,
   output logic                   bank_restore_mode
);
   import hazard_pkg::*;

   localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

   // Guaranteed groups see updates on the next instruction
   function automatic logic in_set(input logic [4:0] g);
      in_set = (g == 5'd0) || (g == 5'd1) || (g == 5'd2) || (g == 5'd5)
            || (g == 5'd10) || (g == 5'd12) || (g == 5'd13); // RULE_01
   endfunction

   function automatic logic is_reg(input logic [4:0] g, input logic [4:0] n,
                                   input logic [4:0] rg, input logic [4:0] rn);
      is_reg = (g == rg) && (n == rn);
   endfunction

   logic [31:0]   psw_q;
   logic [31:0]   exception_vector_base_q;
   logic [3:0]    level_q;
   logic          bank_md_q;
   logic          bank_md_sync_q;
   logic [IW-1:0] idx_q;
   logic [IW-1:0] idx_read_q;
   logic [31:0]   lower_q [ENTRIES];
   logic [31:0]   upper_q [ENTRIES];
   logic [31:0]   attr_q  [ENTRIES];
   logic [31:0]   other_q;
   logic [31:0]   other_pend_q;
   logic          other_busy_q;
   logic [3:0]    late_cnt_q;
   logic          guest_q;
   logic          stale_q;
   logic          unsync_q;
   logic [31:0]   psw_fetch_q;
   logic [31:0]   exception_vector_base_fetch_q;
   logic [31:0]   prdata_q;

   logic wr;
   logic rd;
   logic sync;
   logic ebv_now;
   logic apb_setup;
   logic apb_wr;
   logic mapped;
   logic [31:0] psw_wr;

   assign wr   = instr_valid && (instr_op == OP_SR_WRITE);
   assign rd   = instr_valid && (instr_op == OP_SR_READ);
   assign sync = instr_valid && (instr_op == OP_FETCH_SYNC || instr_op == OP_PIPE_SYNC);

   // Guest mode pins base select, so readers always see it set
   assign ebv_now = guest_q | psw_q[PSW_EBV]; // RULE_11

   // Status word as written, with base select protected in guest mode
   always_comb
   begin
      psw_wr = instr_wdata;
      if (guest_q)
      begin
         psw_wr[PSW_EBV] = 1'b1; // RULE_11
      end
   end

   // Status word: written directly or by mask and unmask instructions
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         psw_q <= PSW_RESET;
      end
      else if (wr && is_reg(register_group_select, instr_regnum, GRP_PSW, NUM_PSW))
      begin
         psw_q <= psw_wr; // RULE_01
      end
      else if (instr_valid && instr_op == OP_MASK)
      begin
         psw_q[PSW_ID] <= 1'b1; // RULE_03
      end
      else if (instr_valid && instr_op == OP_UNMASK)
      begin
         psw_q[PSW_ID] <= 1'b0; // RULE_03
      end
   end

   // Vector base and interrupt acceptance level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         exception_vector_base_q <= EXCEPTION_VECTOR_BASE_RESET;
         level_q <= LEVEL_RESET;
      end
      else if (wr)
      begin
         if (is_reg(register_group_select, instr_regnum, GRP_EXCEPTION_VECTOR_BASE, NUM_EXCEPTION_VECTOR_BASE))
         begin
            exception_vector_base_q <= instr_wdata; // RULE_01
         end
         if (is_reg(register_group_select, instr_regnum, GRP_INT, NUM_LEVEL))
         begin
            level_q <= instr_wdata[3:0]; // RULE_04
         end
      end
   end

   // Bank mode: live for interrupts, restore waits for a sync
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_md_q      <= 1'b0;
         bank_md_sync_q <= 1'b0;
      end
      else
      begin
         if (wr && is_reg(register_group_select, instr_regnum, GRP_INT, NUM_BANK0))
         begin
            bank_md_q <= instr_wdata[0]; // RULE_05
         end
         if (sync)
         begin
            bank_md_sync_q <= bank_md_q; // RULE_05
         end
      end
   end

   // Restore uses the synced mode; an unsynced change is not relied upon
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_restore_mode <= 1'b0;
      end
      else if (instr_valid && instr_op == OP_BANK_REST)
      begin
         bank_restore_mode <= bank_md_sync_q; // RULE_05
      end
   end

   // Entry index: writes see it at once, reads only after a sync
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idx_q      <= '0;
         idx_read_q <= '0;
      end
      else
      begin
         if (wr && is_reg(register_group_select, instr_regnum, GRP_MPU, NUM_IDX))
         begin
            idx_q <= instr_wdata[IW-1:0]; // RULE_06
         end
         if (sync)
         begin
            idx_read_q <= idx_q; // RULE_07
         end
      end
   end

   // Region entries, addressed by the live index
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < ENTRIES; i++)
         begin
            lower_q[i] <= '0;
            upper_q[i] <= '0;
            attr_q[i]  <= '0;
         end
      end
      else if (wr && register_group_select == GRP_MPU)
      begin
         case (instr_regnum)
            NUM_LOWER: lower_q[idx_q] <= instr_wdata; // RULE_06
            NUM_UPPER: upper_q[idx_q] <= instr_wdata; // RULE_06
            NUM_ATTR:  attr_q[idx_q]  <= instr_wdata; // RULE_06
            default:   ;
         endcase
      end
   end

   // Register outside the set lands on a sync or some cycles later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         other_q      <= '0;
         other_pend_q <= '0;
         other_busy_q <= 1'b0;
         late_cnt_q   <= '0;
      end
      else if (wr && !in_set(register_group_select)
               && is_reg(register_group_select, instr_regnum, GRP_OTHER, NUM_OTHER))
      begin
         other_pend_q <= instr_wdata; // RULE_13
         other_busy_q <= 1'b1;
         late_cnt_q   <= LATE_CYCLES;
      end
      else if (other_busy_q && (sync || late_cnt_q == 4'h1))
      begin
         other_q      <= other_pend_q; // RULE_08
         other_busy_q <= 1'b0;
         late_cnt_q   <= '0;
      end
      else if (other_busy_q)
      begin
         late_cnt_q <= late_cnt_q - 4'h1; // RULE_13
      end
   end

   // Fetch-side copies move only on a synchronisation instruction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         psw_fetch_q   <= PSW_RESET;
         exception_vector_base_fetch_q <= EXCEPTION_VECTOR_BASE_RESET;
      end
      else if (sync)
      begin
         psw_fetch_q   <= psw_q;   // RULE_02
         exception_vector_base_fetch_q <= exception_vector_base_q; // RULE_08
      end
   end

   // Hazard flags: region read with unsynced index, restore with unsynced mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stale_q  <= 1'b0;
         unsync_q <= 1'b0;
      end
      else
      begin
         if (rd && register_group_select == GRP_MPU && instr_regnum != NUM_IDX
             && idx_read_q != idx_q)
         begin
            stale_q <= 1'b1; // RULE_07
         end
         else if (apb_wr && paddr == A_HAZARD && pwdata[0])
         begin
            stale_q <= 1'b0;
         end
         if (instr_valid && instr_op == OP_BANK_REST && bank_md_sync_q != bank_md_q)
         begin
            unsync_q <= 1'b1; // RULE_05
         end
         else if (apb_wr && paddr == A_HAZARD && pwdata[1])
         begin
            unsync_q <= 1'b0;
         end
      end
   end

   // Read instruction result; region reads use the synced index
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         instr_rdata <= '0;
      end
      else if (rd)
      begin
         if (is_reg(register_group_select, instr_regnum, GRP_PSW, NUM_PSW))
            instr_rdata <= {psw_q[31:PSW_EBV+1], ebv_now, psw_q[PSW_EBV-1:0]};
         else if (is_reg(register_group_select, instr_regnum, GRP_EXCEPTION_VECTOR_BASE, NUM_EXCEPTION_VECTOR_BASE))
            instr_rdata <= exception_vector_base_q;
         else if (is_reg(register_group_select, instr_regnum, GRP_INT, NUM_LEVEL))
            instr_rdata <= {28'h000_0000, level_q};
         else if (is_reg(register_group_select, instr_regnum, GRP_INT, NUM_BANK0))
            instr_rdata <= {31'h0000_0000, bank_md_q};
         else if (is_reg(register_group_select, instr_regnum, GRP_MPU, NUM_IDX))
            instr_rdata <= 32'(idx_q);
         else if (is_reg(register_group_select, instr_regnum, GRP_MPU, NUM_LOWER))
            instr_rdata <= lower_q[idx_read_q]; // RULE_07
         else if (is_reg(register_group_select, instr_regnum, GRP_MPU, NUM_UPPER))
            instr_rdata <= upper_q[idx_read_q]; // RULE_07
         else if (is_reg(register_group_select, instr_regnum, GRP_MPU, NUM_ATTR))
            instr_rdata <= attr_q[idx_read_q]; // RULE_07
         else if (is_reg(register_group_select, instr_regnum, GRP_OTHER, NUM_OTHER))
            instr_rdata <= other_q;
         else
            instr_rdata <= '0;
      end
   end

   // Acceptance uses this cycle's registers, which already hold last write
   assign irq_accept = irq_req && instr_valid && !psw_q[PSW_ID]
                       && (irq_level < level_q); // RULE_04

   // Vector base follows base select; handler address is reset base otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vector_base <= RESET_VECTOR;
      end
      else
      begin
         vector_base <= ebv_now ? exception_vector_base_q : RESET_VECTOR; // RULE_09
      end
   end

   assign exec_psw    = {psw_q[31:PSW_EBV+1], ebv_now, psw_q[PSW_EBV-1:0]};
   assign fetch_psw   = psw_fetch_q;
   assign fetch_exception_vector_base = exception_vector_base_fetch_q;

   // APB slave: read data captured in setup, answer in first access cycle
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;
   assign mapped    = (paddr == A_CTRL) || (paddr == A_PSW) || (paddr == A_VECTOR)
                      || (paddr == A_INDEX) || (paddr == A_HAZARD);
   assign pready    = psel && penable;
   assign pslverr   = psel && penable && !mapped;
   assign prdata    = prdata_q;

   // Guest mode is steered by software through the control word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         guest_q <= 1'b0;
      end
      else if (apb_wr && paddr == A_CTRL)
      begin
         guest_q <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= '0;
      end
      else if (apb_setup)
      begin
         case (paddr)
            A_CTRL:   prdata_q <= {31'h0000_0000, guest_q};
            A_PSW:    prdata_q <= exec_psw;
            A_VECTOR: prdata_q <= vector_base;
            A_INDEX:  prdata_q <= 32'(idx_q);
            A_HAZARD: prdata_q <= {29'h0000_0000, other_busy_q, unsync_q, stale_q};
            default:  prdata_q <= '0;
         endcase
      end
   end
endmodule

// *** verif/sysreg_hazard_properties.sv ***
// Checker for sysreg_hazard: instruction-port and status-word timing.
// Assumes it is bound to sysreg_hazard and sees only that module's ports.
`timescale 1ns/100ps
module sysreg_hazard_checker
#(
   parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
)
(
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [7:0]       paddr,
   input wire logic [31:0]      pwdata,
   input wire logic             instr_valid,
   input wire hazard_pkg::op_e  instr_op,
   input wire logic [4:0]       register_group_select,
   input wire logic [4:0]       instr_regnum,
   input wire logic [31:0]      instr_wdata,
   input wire logic [31:0]      instr_rdata,
   input wire logic             irq_req,
   input wire logic             irq_accept,
   input wire logic [31:0]      exec_psw,
   input wire logic [31:0]      fetch_psw,
   input wire logic [31:0]      vector_base,
   input wire logic             bank_restore_mode
);
   import hazard_pkg::*;
   logic guest_q;
   logic psw_hit;
   logic sync_op;

   // Decode of the status-word target and of either sync instruction
   assign psw_hit = register_group_select == GRP_PSW && instr_regnum == NUM_PSW;
   assign sync_op = instr_valid && (instr_op == OP_FETCH_SYNC || instr_op == OP_PIPE_SYNC);

   // Shadow of guest mode, since the checker cannot see the control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         guest_q <= 1'b0;
      else if (psel && penable && pwrite && paddr == A_CTRL)
         guest_q <= pwdata[0];
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   psw_write_next_a:
   assert property (instr_valid && instr_op == OP_SR_WRITE && psw_hit
      |=> exec_psw[PSW_ID] == $past(instr_wdata[PSW_ID])) else $error("status write late");
   psw_read_next_a:
   assert property (instr_valid && instr_op == OP_SR_READ && psw_hit
      |=> instr_rdata == $past(exec_psw)) else $error("status read wrong");
   mask_next_a:
   assert property (instr_valid && instr_op == OP_MASK |=> exec_psw[PSW_ID])
      else $error("mask not seen next cycle");
   unmask_next_a:
   assert property (instr_valid && instr_op == OP_UNMASK |=> !exec_psw[PSW_ID])
      else $error("unmask not seen next cycle");
   accept_cause_a:
   assert property (irq_accept |-> irq_req && instr_valid && !exec_psw[PSW_ID])
      else $error("interrupt taken while masked");
   fetch_copy_hold_a:
   assert property (!sync_op |=> $stable(fetch_psw)) else $error("fetch copy moved without sync");
   vector_select_a:
   assert property (!exec_psw[PSW_EBV] |=> vector_base == RESET_VECTOR)
      else $error("vector base used while select clear");
   guest_select_a:
   assert property (guest_q |-> exec_psw[PSW_EBV]) else $error("select clear in guest mode");
   bank_mode_hold_a:
   assert property (!(instr_valid && instr_op == OP_BANK_REST) |=> $stable(bank_restore_mode))
      else $error("restore mode moved without restore");
endmodule

bind sysreg_hazard sysreg_hazard_checker #(.RESET_VECTOR(RESET_VECTOR)) sysreg_hazard_checker_inst
   (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .instr_valid, .instr_op,
    .register_group_select, .instr_regnum, .instr_wdata, .instr_rdata, .irq_req,
    .irq_accept, .exec_psw, .fetch_psw, .vector_base, .bank_restore_mode);

// *** verif/sysreg_hazard_tb_top.sv ***
// Self-checking bench for sysreg_hazard over APB and the instruction port.
// Assumes the checker file is compiled with it; one 25 MHz clock.
`timescale 1ns/100ps
module sysreg_hazard_tb_top;
   import hazard_pkg::*;
   localparam logic [31:0] RV = 32'h0000_0400;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        instr_valid, irq_req, irq_accept, bank_restore_mode;
   logic [7:0]  paddr;
   logic [4:0]  register_group_select, instr_regnum;
   logic [3:0]  irq_level;
   logic [31:0] pwdata, prdata, instr_wdata, instr_rdata, exec_psw, fetch_psw;
   logic [31:0] fetch_exception_vector_base, vector_base, rd;
   op_e         instr_op;
   int          fail_count, checked;

   sysreg_hazard #(.ENTRIES(8), .RESET_VECTOR(RV)) sysreg_hazard_inst
      (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
       .pslverr, .instr_valid, .instr_op, .register_group_select, .instr_regnum,
       .instr_wdata, .instr_rdata, .irq_req, .irq_level, .irq_accept, .exec_psw,
       .fetch_psw, .fetch_exception_vector_base, .vector_base, .bank_restore_mode);

   // Free-running core clock
   always #20 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One instruction; it stays valid until the next call, so chains end in a NOP
   task automatic ins(input op_e op, input logic [4:0] g = 5'h00,
                      input logic [4:0] n = 5'h00, input logic [31:0] d = 32'h0);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_op <= op;
      register_group_select <= g;
      instr_regnum <= n;
      instr_wdata <= d;
   endtask

   // Issue a NOP so the previous instruction is taken, then let updates land
   task automatic settle;
      ins(OP_NOP);
      #1;
   endtask

   // APB transfer; also retires the instruction still on the port
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
      @(posedge pclk);
      instr_valid <= 1'b0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_reset;
      chk(vector_base, RV);
      apb(1'b0, A_PSW);
      chk(rd, PSW_RESET);
      apb(1'b0, 8'h20);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset done");
   endtask

   // Mask changes and level writes must govern the very next acceptance
   task automatic t_irq;
      @(posedge pclk);
      irq_req <= 1'b1;
      irq_level <= 4'h3;
      ins(OP_UNMASK);
      settle;
      chk(32'(irq_accept), 32'h1);
      ins(OP_MASK);
      settle;
      chk(32'(irq_accept), 32'h0);
      ins(OP_SR_WRITE, GRP_PSW, NUM_PSW, 32'h0);
      settle;
      chk(32'(irq_accept), 32'h1);
      ins(OP_SR_WRITE, GRP_INT, NUM_LEVEL, 32'h3);
      settle;
      chk(32'(irq_accept), 32'h0);
      ins(OP_SR_WRITE, GRP_INT, NUM_LEVEL, 32'hf);
      settle;
      chk(32'(irq_accept), 32'h1);
      ins(OP_MASK);
      apb(1'b0, A_PSW);
      irq_req <= 1'b0;
      $display("test irq done");
   endtask

   // Index then bound back to back; reads follow the synced index only
   task automatic t_region;
      ins(OP_SR_WRITE, GRP_MPU, NUM_IDX, 32'h3);
      ins(OP_SR_WRITE, GRP_MPU, NUM_LOWER, 32'ha5);
      ins(OP_SR_WRITE, GRP_MPU, NUM_IDX, 32'h1);
      ins(OP_SR_WRITE, GRP_MPU, NUM_LOWER, 32'h11);
      ins(OP_SR_WRITE, GRP_MPU, NUM_IDX, 32'h3);
      ins(OP_PIPE_SYNC);
      ins(OP_SR_READ, GRP_MPU, NUM_LOWER);
      settle;
      chk(instr_rdata, 32'ha5);
      ins(OP_SR_WRITE, GRP_MPU, NUM_IDX, 32'h1);
      ins(OP_SR_READ, GRP_MPU, NUM_LOWER);
      // Let the read retire first: the bus captures read data in its setup cycle
      settle;
      chk(instr_rdata, 32'ha5);
      apb(1'b0, A_HAZARD);
      chk(32'(rd[0]), 32'h1);
      ins(OP_FETCH_SYNC);
      ins(OP_SR_READ, GRP_MPU, NUM_LOWER);
      settle;
      chk(instr_rdata, 32'h11);
      ins(OP_SR_WRITE, GRP_MPU, NUM_UPPER, 32'h0000_0077);
      ins(OP_SR_WRITE, GRP_MPU, NUM_ATTR, 32'h0000_0033);
      ins(OP_SR_READ, GRP_MPU, NUM_UPPER);
      settle;
      chk(instr_rdata, 32'h0000_0077);
      ins(OP_SR_READ, GRP_MPU, NUM_ATTR);
      settle;
      chk(instr_rdata, 32'h0000_0033);
      apb(1'b0, A_INDEX);
      chk(rd, 32'h0000_0001);
      $display("test region done");
   endtask

   // Masked base update, then guest mode pins the select bit
   task automatic t_exception_vector_base;
      ins(OP_SR_WRITE, GRP_PSW, NUM_PSW, 32'h0000_0020);
      ins(OP_SR_WRITE, GRP_EXCEPTION_VECTOR_BASE, NUM_EXCEPTION_VECTOR_BASE, 32'h0000_8000);
      ins(OP_SR_WRITE, GRP_PSW, NUM_PSW, 32'h0000_8020);
      ins(OP_SR_WRITE, GRP_PSW, NUM_PSW, 32'h0000_8000);
      settle;
      settle;
      chk(vector_base, 32'h0000_8000);
      chk(fetch_exception_vector_base, EXCEPTION_VECTOR_BASE_RESET);
      chk(fetch_psw, 32'h0000_0020);
      apb(1'b0, A_VECTOR);
      chk(rd, 32'h0000_8000);
      ins(OP_FETCH_SYNC);
      settle;
      chk(fetch_exception_vector_base, 32'h0000_8000);
      chk(fetch_psw, 32'h0000_8000);
      apb(1'b1, A_CTRL, 32'h1);
      ins(OP_SR_WRITE, GRP_PSW, NUM_PSW, 32'h0000_0020);
      settle;
      chk(32'(exec_psw[PSW_EBV]), 32'h1);
      ins(OP_SR_READ, GRP_PSW, NUM_PSW);
      settle;
      chk(instr_rdata, 32'h0000_8020);
      apb(1'b1, A_CTRL, 32'h0);
      ins(OP_SR_WRITE, GRP_PSW, NUM_PSW, 32'h0000_0020);
      settle;
      settle;
      chk(vector_base, RV);
      $display("test exception_vector_base done");
   endtask

   // Outside the set the write lands late; here the late count lands it one cycle before the sync is taken
   task automatic t_other;
      ins(OP_SR_WRITE, GRP_OTHER, NUM_OTHER, 32'h0000_5a5a);
      // The write must retire before the setup cycle captures the busy flag
      settle;
      apb(1'b0, A_HAZARD);
      chk(32'(rd[2]), 32'h1);
      ins(OP_PIPE_SYNC);
      ins(OP_SR_READ, GRP_OTHER, NUM_OTHER);
      settle;
      chk(instr_rdata, 32'h0000_5a5a);
      $display("test other done");
   endtask

   // Restore right after a mode change keeps the old mode until a sync
   task automatic t_bank;
      ins(OP_SR_WRITE, GRP_INT, NUM_BANK0, 32'h1);
      ins(OP_BANK_REST);
      settle;
      chk(32'(bank_restore_mode), 32'h0);
      apb(1'b0, A_HAZARD);
      chk(32'(rd[1]), 32'h1);
      apb(1'b1, A_HAZARD, 32'h2);
      apb(1'b0, A_HAZARD);
      chk(32'(rd[1]), 32'h0);
      ins(OP_PIPE_SYNC);
      ins(OP_BANK_REST);
      settle;
      chk(32'(bank_restore_mode), 32'h1);
      $display("test bank done");
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, instr_valid, irq_req} = 7'h0;
      {paddr, pwdata, register_group_select, instr_regnum, instr_wdata} = 82'h0;
      instr_op = OP_NOP;
      irq_level = 4'hf;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_irq;
      t_region;
      t_exception_vector_base;
      t_other;
      t_bank;
      close_out;
   end

   // Tests need under two hundred cycles; far beyond that means a hang
   initial
   begin
      repeat (4000) @(posedge pclk);
      fail_count++;
      close_out;
   end
endmodule
